/* File: logic/drl_serial_readout.sv */
`timescale 1ns/1ps
`default_nettype none

module drl_serial_readout #(
  parameter int unsigned FIFO_DEPTH = drl_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [drl_pkg::DATA_BITS-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  output logic dout_o,
  output logic dout_oe_o,
  output logic power_down_o,
  output logic converting_o,
  output logic underrun_o
);

  // ==========================================================
  // pin synchronisers and sample buffer
  drl_link_if link ();
  drl_stream_if #(.W(drl_pkg::DATA_BITS)) in_s ();
  drl_stream_if #(.W(drl_pkg::DATA_BITS)) out_s ();

  drl_pin_sync u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .cs_n_pin_i(cs_n_i),
    .sclk_pin_i(sclk_i),
    .link(link.drv)
  );

  assign in_s.valid = sample_valid_i;
  assign in_s.data = sample_i;
  assign sample_ready_o = in_s.ready;

  // the front end keeps filling while asleep; a full buffer stalls it
  drl_fifo #(.WIDTH(drl_pkg::DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .wr(in_s.snk),
    .rd(out_s.src)
  );

  // ==========================================================
  // sequencer state
  typedef struct packed {
    drl_pkg::drl_state_e state;
    logic [drl_pkg::WORD_BITS-1:0] shreg;
    logic [drl_pkg::CNT_W-1:0] falls;
    logic dout;
    logic oe;
    logic underrun;
  } drl_core_s;

  drl_core_s st;
  drl_core_s next_st;
  logic take;

  // sample is taken only at the frame opening, and only while asleep
  assign take = (st.state == drl_pkg::DRL_SLEEP) && link.cs_fall;
  assign out_s.ready = take;

  always_comb begin
    next_st = st;
    unique case (st.state)
      drl_pkg::DRL_SLEEP: begin
        next_st.oe = 1'b0;
        next_st.dout = drl_pkg::DOUT_IDLE;
        if (take) begin
          // empty buffer sends a zero code rather than stale data
          next_st.shreg = {drl_pkg::NULL_FIELD,
                           out_s.valid ? out_s.data : drl_pkg::SAMPLE_RESET};
          next_st.underrun = ~out_s.valid;
          next_st.falls = drl_pkg::CNT_RESET;
          next_st.dout = drl_pkg::NULL_FIELD[drl_pkg::NULL_BITS-1];
          next_st.oe = 1'b1;
          next_st.state = drl_pkg::DRL_SHIFT;
        end
      end
      drl_pkg::DRL_SHIFT: begin
        if (!link.cs_low) begin
          // early rise aborts the frame and releases the line at once
          next_st.oe = 1'b0;
          next_st.dout = drl_pkg::DOUT_IDLE;
          next_st.state = drl_pkg::DRL_SLEEP;
        end else if (link.sclk_fall) begin
          next_st.falls = st.falls + 1'b1;
          next_st.shreg = {st.shreg[drl_pkg::WORD_BITS-2:0], 1'b0};
          if (st.falls == drl_pkg::LAST_FALL) begin
            next_st.dout = drl_pkg::DOUT_IDLE;
            next_st.state = drl_pkg::DRL_DONE;
          end else begin
            next_st.dout = st.shreg[drl_pkg::WORD_BITS-2];
          end
        end
      end
      drl_pkg::DRL_DONE: begin
        if (!link.cs_low) begin
          next_st.oe = 1'b0;
          next_st.state = drl_pkg::DRL_SLEEP;
        end
      end
      default: begin
        next_st.state = drl_pkg::DRL_SLEEP;
        next_st.oe = 1'b0;
        next_st.dout = drl_pkg::DOUT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{drl_pkg::DRL_SLEEP, drl_pkg::WORD_RESET, drl_pkg::CNT_RESET,
              drl_pkg::DOUT_IDLE, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign dout_o = st.dout;
  assign dout_oe_o = st.oe;
  assign power_down_o = (st.state == drl_pkg::DRL_SLEEP);
  assign converting_o = (st.state == drl_pkg::DRL_SHIFT);
  assign underrun_o = st.underrun;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // a frame step is a clock fall while the frame is still selected
  function automatic logic frame_step(input drl_pkg::drl_state_e s, input logic low,
                                      input logic fall);
    frame_step = (s == drl_pkg::DRL_SHIFT) && low && fall;
  endfunction

  chk_active_drive: assert property (
    (st.state == drl_pkg::DRL_SHIFT) && link.cs_low |=> dout_oe_o
  ) else $error("line not driven during an active frame");

  chk_sleep_no_take: assert property (
    !link.cs_low |-> !out_s.ready ##1 power_down_o
  ) else $error("sample taken or awake while select is high");

  chk_start_on_fall: assert property (
    link.cs_fall && power_down_o |=> converting_o && dout_oe_o && (st.falls == '0)
  ) else $error("conversion did not start on select fall");

  chk_null_lead: assert property (
    dout_oe_o && converting_o && (st.falls < drl_pkg::NULL_CNT) |-> !dout_o
  ) else $error("null bit not zero");

  chk_msb_order: assert property (
    converting_o && link.cs_low && link.sclk_fall && (st.falls != drl_pkg::LAST_FALL)
      |=> dout_o == $past(st.shreg[drl_pkg::WORD_BITS-2])
  ) else $error("bits not sent most significant first");

  chk_change_on_fall: assert property (
    converting_o && $past(converting_o) && $changed(dout_o) |-> $past(link.sclk_fall)
  ) else $error("data changed away from a clock fall");

  chk_sclk_paces: assert property (
    converting_o && link.cs_low && !link.sclk_fall |=> $stable(st.falls) && $stable(st.shreg)
  ) else $error("frame advanced without a clock fall");

  chk_twos_data: assert property (
    take && out_s.valid
      |=> st.shreg[drl_pkg::DATA_BITS-1:0] == $past(out_s.data) && !underrun_o
  ) else $error("result code differs from buffered sample");

  chk_frame_length: assert property (
    $rose(st.state == drl_pkg::DRL_DONE) |-> st.falls == drl_pkg::FRAME_FALLS && !dout_o
  ) else $error("frame did not end after sixteen falls");

  chk_release_line: assert property (
    !link.cs_low |=> !dout_oe_o ##1 (!dout_oe_o || $past(link.cs_fall))
  ) else $error("line still driven while select is high");

  // ==========================================================
  // frame sequencing detail
  chk_sleep_quiet: assert property (
    power_down_o |-> !dout_oe_o && !dout_o && !converting_o
  ) else $error("asleep but line driven or frame running");

  chk_off_is_zero: assert property (
    !dout_oe_o |-> !dout_o
  ) else $error("released line shows a one");

  chk_no_take_busy: assert property (
    !power_down_o |-> !out_s.ready
  ) else $error("sample popped inside a frame");

  chk_pop_on_fall: assert property (
    out_s.ready |-> link.cs_fall && link.cs_low
  ) else $error("sample popped without a select fall");

  chk_done_holds: assert property (
    (st.state == drl_pkg::DRL_DONE) && link.cs_low
      |=> (st.state == drl_pkg::DRL_DONE) && dout_oe_o && !dout_o
  ) else $error("finished frame left before select rose");

  chk_last_fall: assert property (
    frame_step(st.state, link.cs_low, link.sclk_fall) && (st.falls == drl_pkg::LAST_FALL)
      |=> (st.state == drl_pkg::DRL_DONE) && !converting_o
  ) else $error("frame ran past sixteen falls");

  chk_fall_count: assert property (
    frame_step(st.state, link.cs_low, link.sclk_fall) |=> st.falls == $past(st.falls) + 1'b1
  ) else $error("clock fall not counted");

  chk_abort_release: assert property (
    converting_o && !link.cs_low |=> power_down_o && !dout_oe_o
  ) else $error("early select rise did not end the frame");

  chk_first_null: assert property (
    $rose(converting_o) |-> dout_oe_o && !dout_o && (st.falls == drl_pkg::CNT_RESET)
  ) else $error("frame did not open on a null bit");

  chk_empty_code: assert property (
    take && !out_s.valid |=> underrun_o && (st.shreg == drl_pkg::WORD_RESET)
  ) else $error("empty buffer did not send the zero code");

  chk_active_awake: assert property (
    converting_o |-> !power_down_o && dout_oe_o
  ) else $error("frame running while asleep or released");

  chk_oe_on_start: assert property (
    $rose(dout_oe_o) |-> $past(take) && converting_o
  ) else $error("line driven without a frame start");

  chk_underrun_hold: assert property (
    !take |=> $stable(underrun_o)
  ) else $error("underrun flag moved outside a frame start");

  chk_idle_sclk: assert property (
    power_down_o && !link.cs_low && link.sclk_fall |=> power_down_o && $stable(st.shreg)
  ) else $error("clock fall while deselected woke the block");

  chk_frame_bound: assert property (
    converting_o |-> st.falls <= drl_pkg::LAST_FALL
  ) else $error("fall count beyond the frame");

  chk_bit_hold: assert property (
    converting_o && !link.sclk_fall |=> !converting_o || $stable(dout_o)
  ) else $error("data moved without a clock fall");

  cov_full_frame: cover property (
    converting_o ##[1:1000] (st.state == drl_pkg::DRL_DONE) ##[1:1000] power_down_o
  );

  cov_abort_frame: cover property (
    converting_o && !link.cs_low && (st.falls < drl_pkg::LAST_FALL)
  );

  cov_underrun: cover property (
    take && !out_s.valid
  );

  cov_buffer_full: cover property (
    sample_valid_i && !sample_ready_o
  );

  cov_idle_clock: cover property (
    power_down_o && !link.cs_low && link.sclk_fall
  );

endmodule

`default_nettype wire

/* File: logic/drl_pkg.sv */
package drl_pkg;

  // ==========================================================
  // word layout
  localparam int unsigned NULL_BITS = 4;
  localparam int unsigned DATA_BITS = 12;
  localparam int unsigned WORD_BITS = NULL_BITS + DATA_BITS;
  localparam int unsigned CNT_W = 5;

  // ==========================================================
  // frame counting, in serial clock falls
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
  localparam logic [CNT_W-1:0] NULL_CNT = 5'h04;
  localparam logic [CNT_W-1:0] LAST_FALL = 5'h0F;
  localparam logic [CNT_W-1:0] FRAME_FALLS = 5'h10;

  // ==========================================================
  // reset and idle values
  localparam logic [NULL_BITS-1:0] NULL_FIELD = 4'h0;
  localparam logic [DATA_BITS-1:0] SAMPLE_RESET = 12'h000;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic CS_IDLE = 1'h1;
  localparam logic SCLK_IDLE = 1'h0;
  localparam logic DOUT_IDLE = 1'h0;

  // ==========================================================
  // buffering
  localparam int unsigned FIFO_DEPTH = 8;

  // ==========================================================
  // readout sequencer
  typedef enum logic [2:0] {
    DRL_SLEEP = 3'h1,
    DRL_SHIFT = 3'h2,
    DRL_DONE = 3'h4
  } drl_state_e;

endpackage

/* File: logic/drl_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// synchronised link events
interface drl_link_if;
  logic cs_fall;
  logic cs_low;
  logic sclk_fall;
  logic sclk_rise;
  modport drv (output cs_fall, output cs_low, output sclk_fall, output sclk_rise);
  modport mon (input cs_fall, input cs_low, input sclk_fall, input sclk_rise);
endinterface

// ==========================================================
// sample stream
interface drl_stream_if #(
  parameter int unsigned W = 12
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* File: logic/drl_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module drl_pin_sync (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic cs_n_pin_i,
  input wire logic sclk_pin_i,
  drl_link_if.drv link
);

  // ==========================================================
  // state: two sync stages plus one history stage per pin
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
  } drl_sync_s;

  drl_sync_s st;
  drl_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.cs_s1 = cs_n_pin_i;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_s3 = st.cs_s2;
    next_st.sclk_s1 = sclk_pin_i;
    next_st.sclk_s2 = st.sclk_s1;
    next_st.sclk_s3 = st.sclk_s2;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{drl_pkg::CS_IDLE, drl_pkg::CS_IDLE, drl_pkg::CS_IDLE,
              drl_pkg::SCLK_IDLE, drl_pkg::SCLK_IDLE, drl_pkg::SCLK_IDLE};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // edges only from stages two and three, never stage one
  assign link.cs_fall = st.cs_s3 & ~st.cs_s2;
  assign link.cs_low = ~st.cs_s2;
  assign link.sclk_fall = st.sclk_s3 & ~st.sclk_s2;
  assign link.sclk_rise = ~st.sclk_s3 & st.sclk_s2;

endmodule

`default_nettype wire

/* File: logic/drl_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module drl_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  drl_stream_if.snk wr,
  drl_stream_if.src rd
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  // ==========================================================
  // state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } drl_fifo_s;

  drl_fifo_s st;
  drl_fifo_s next_st;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  // honest flags: full stalls the source, empty stalls the reader
  assign wr.ready = (st.count != FULL_COUNT);
  assign rd.valid = (st.count != '0);
  assign rd.data = st.mem[st.rptr];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wptr] = wr.data;
      next_st.wptr = bump(st.wptr);
    end
    if (pop) begin
      next_st.rptr = bump(st.rptr);
    end
    next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

/* File: tb/drl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// serial host: drives select and the link clock, reads on rises
module drl_host_model #(
  parameter int HALF_NS = 400 // scaled below range so the 10 MHz sampler sees it
) (
  input wire logic dout_i,
  input wire logic oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output int bad_o
);
  logic last_q;
  wire logic line_w;

  // a released line reads as the inverse of the last bit taken
  assign line_w = (oe_i === 1'b1) ? dout_i : ~last_q;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0; // stands still low between frames except while idle_clocks runs
    bad_o = 0;
    last_q = 1'b0;
  end

  // data may only move while the link clock is low
  always @(dout_i) begin
    if (!cs_n_o && sclk_o && oe_i === 1'b1) begin
      bad_o = bad_o + 1;
    end
  end

  // limitation: 800 ns clock, slower than the real part, so the sampler sees every edge
  task automatic run_frame(input int falls, output logic [15:0] w);
    w = 16'h0000;
    #33;
    cs_n_o = 1'b0; // each frame opens with select falling
    #(HALF_NS);
    for (int i = 0; i < falls; i++) begin
      sclk_o = 1'b1; // same clock paces data and conversion
      w = {w[14:0], line_w}; // bit taken on the rise
      last_q = line_w;
      #(HALF_NS);
      sclk_o = 1'b0;
      #(HALF_NS);
    end
    cs_n_o = 1'b1; // full frames keep select low sixteen cycles
    #(4 * HALF_NS); // frame pitch follows the scaled link clock
  endtask

  // link clock toggled while deselected
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #(HALF_NS) sclk_o = 1'b1;
      #(HALF_NS) sclk_o = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [11:0] sample_i = 12'h000;
  logic sample_valid_i = 1'b0;
  wire logic cs_n_w, sclk_w, ready_w, dout_w, oe_w, pd_w, conv_w, under_w;
  int bad_w;
  int fails = 0;
  int num_checks = 0;
  logic [15:0] w;
  bit ok;
  logic [11:0] tbl [4] = '{12'h800, 12'h7FF, 12'hFFF, 12'h001};

  always #50 mclk_i = ~mclk_i;

  drl_serial_readout i_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_w), .sclk_i(sclk_w),
    .sample_i(sample_i), .sample_valid_i(sample_valid_i), .sample_ready_o(ready_w),
    .dout_o(dout_w), .dout_oe_o(oe_w), .power_down_o(pd_w), .converting_o(conv_w),
    .underrun_o(under_w)
  );

  drl_host_model i_host (
    .dout_i(dout_w), .oe_i(oe_w), .cs_n_o(cs_n_w), .sclk_o(sclk_w), .bad_o(bad_w)
  );

  // ==========================================================
  // shared helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // valid stays up on return; the caller lowers it at a later edge
  task automatic push(input logic [11:0] d, output bit acc);
    @(posedge mclk_i);
    sample_i <= d;
    sample_valid_i <= 1'b1;
    @(negedge mclk_i);
    acc = (ready_w === 1'b1);
  endtask

  task automatic drop();
    @(posedge mclk_i);
    sample_valid_i <= 1'b0;
  endtask

  task automatic frame(input int falls, output logic [15:0] wd);
    fork
      i_host.run_frame(falls, wd);
      begin
        #2000;
        check("converting", conv_w, 1'b1);
        check("awake", pd_w, 1'b0);
        check("driving", oe_w, 1'b1);
      end
    join
    check("released", oe_w, 1'b0);
    check("asleep", pd_w, 1'b1);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    repeat (5) @(posedge mclk_i);
    check("rst asleep", pd_w, 1'b1);
    check("rst oe", oe_w, 1'b0);
    check("rst ready", ready_w, 1'b1);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
  endtask

  // sign extremes back to back
  task automatic t_codes();
    foreach (tbl[i]) begin
      push(tbl[i], ok);
      drop();
      frame(16, w);
      check("code word", w, {4'h0, tbl[i]});
      check("no underrun", under_w, 1'b0);
    end
  endtask

  // fill until refused, drain in order, then one frame on empty
  task automatic t_fill();
    for (int i = 0; i < 8; i++) begin
      push(12'h111 * i[11:0] + 12'h00A, ok);
      check("accepted", ok, 1'b1);
    end
    push(12'hABC, ok);
    check("refused when full", ok, 1'b0);
    drop();
    for (int i = 0; i < 8; i++) begin
      frame(16, w);
      check("drain word", w, {4'h0, 12'h111 * i[11:0] + 12'h00A});
    end
    frame(16, w);
    check("empty word", w, 16'h0000);
    check("underrun", under_w, 1'b1);
  endtask

  // early deselect, clocks while asleep, then the next word
  task automatic t_abort();
    push(12'hC35, ok);
    push(12'h3CA, ok);
    drop();
    frame(5, w);
    check("partial word", w[4:0], 5'h01);
    i_host.idle_clocks(4);
    check("idle asleep", pd_w, 1'b1);
    check("idle idle", conv_w, 1'b0);
    check("idle oe", oe_w, 1'b0);
    frame(16, w);
    check("after abort", w, {4'h0, 12'h3CA});
    check("edges only on falls", bad_w[15:0], 16'h0000);
  endtask

  // ==========================================================
  // verdict
  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    t_reset();
    t_codes();
    t_fill();
    t_abort();
    report_and_stop();
  end

  // about 15 frames of 15 us each; generous margin
  initial begin
    #1000000;
    fails++;
    report_and_stop();
  end
endmodule

`default_nettype wire
